// ===== dv/octal_switch_config_fault_mask_tb.sv
`timescale 1ns/10ps
module octal_switch_config_fault_mask_tb;
  localparam int unsigned MS = 2;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic wr_en, daisy_strap, addr0_wdog_strap, addr1_sync_wdog_strap, fault_n, comm_error_irq;
  logic supply_error_irq, spi_wdog_en, sync_wdog_enable, restart_level_sel;
  logic serial_supply_error_bit, serial_overload_flag, global_irq_flag;
  logic [7:0] addr, wr_data, rd_data, status_led_int, status_led, error_led, den;
  logic [7:0] raw[5];
  logic [7:0] flg[5];
  logic [2:0] sc;
  logic [1:0] openwire_current_sel, supply_short_thresh_sel;
  logic [31:0] wdog_spi_cycles, wdog_sync_cycles;
  logic [31:0] lf = 32'h345CCD15;
  logic [3:0] q_sel[$];
  logic [31:0] q_exp[$];
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int wd[4] = '{600, 200, 600, 1200};
  logic [7:0] re[7] = '{8'h53, 8'h00, 8'hBE, 8'h00, 8'h00, 8'h00, 8'h00};
  always #20 clk = ~clk;
  oscfm_host u_host (.clk, .wr_en, .addr, .wr_data, .daisy_strap, .addr0_wdog_strap, .addr1_sync_wdog_strap);
  oscfm_core #(.CH(8), .MS_CYCLES(MS)) u_dut (.clk, .rstn, .wr_en, .addr, .wr_data, .rd_data, .daisy_strap,
    .addr0_wdog_strap, .addr1_sync_wdog_strap, .overload_raw(raw[0]), .overcurrent_raw(raw[1]),
    .openwire_off_raw(raw[2]), .openwire_on_raw(raw[3]), .supply_short_raw(raw[4]), .status_led_int,
    .spi_wdog_timeout(sc[2]), .sync_wdog_timeout(sc[2]), .supply_lockout(sc[1]), .supply_below_good(sc[0]),
    .supply_warning(sc[0]), .status_led, .error_led, .fault_n, .overload_flag(flg[0]),
    .overcurrent_flag(flg[1]), .openwire_off_flag(flg[2]), .openwire_on_flag(flg[3]),
    .supply_short_flag(flg[4]), .comm_error_irq, .supply_error_irq, .serial_supply_error_bit,
    .serial_overload_flag, .global_irq_flag, .spi_wdog_en, .sync_wdog_enable, .wdog_spi_cycles,
    .wdog_sync_cycles, .openwire_current_sel, .supply_short_thresh_sel, .restart_level_sel,
    .supply_short_det_en(den), .openwire_on_det_en(den), .openwire_off_det_en(den));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] probe(input logic [3:0] s);
    case (s)
      4'h0: return {24'h0, rd_data};
      4'h1: return {31'h0, fault_n};
      4'h2: return {24'h0, status_led};
      4'h3: return {24'h0, error_led};
      4'h4: return wdog_spi_cycles;
      4'h5: return wdog_sync_cycles;
      4'h6: return {25'h0, spi_wdog_en, sync_wdog_enable, openwire_current_sel, supply_short_thresh_sel,
        restart_level_sel};
      4'h8: return {29'h0, serial_supply_error_bit, serial_overload_flag, global_irq_flag};
      default: return {25'h0, |flg[0], |flg[1], |flg[2], |flg[3], |flg[4], comm_error_irq, supply_error_irq};
    endcase
  endfunction
  task automatic note(input logic [3:0] s, input logic [31:0] e);
    q_sel.push_back(s);
    q_exp.push_back(e);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic src(input int i, input logic v);
    @(posedge clk);
    if (i < 5) raw[i] <= {7'h00, v};
    else sc[i - 5] <= v;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(negedge clk) begin
    while (q_sel.size() > 0) check(probe(q_sel.pop_front()), q_exp.pop_front());
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 40000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    raw = '{default: 8'h00};
    sc = 3'h0;
    status_led_int = 8'h00;
    den = 8'hFF;
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    u_host.wr(8'h12, 8'hFF);
    u_host.wr(8'h13, 8'hFF);
    for (int i = 0; i < 7; i++) begin
      u_host.rd(8'h0D + 8'(i));
      note(4'h0, {24'h0, re[i]});
    end
    note(4'h1, 32'h1);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      u_host.wr(8'h0E, {k[1:0], k[1:0], k[1:0], 1'h1, k[0]});
      tick(3);
      if (k > 0) note(4'h4, 32'(wd[k] * MS));
      note(4'h5, 32'(wd[k] * MS));
      note(4'h6, {25'h0, k > 0, 1'h1, k[1:0], k[1:0], k[0]});
    end
    u_host.strap(1'h1, 1'h1, 1'h0);
    u_host.wr(8'h0E, 8'h00);
    tick(3);
    note(4'h5, 32'(1200 * MS));
    note(4'h6, 32'h41);
    u_host.strap(1'h0, 1'h0, 1'h1);
    $display("config test done");
    for (int i = 0; i < 3; i++) begin
      lf = lfsr(lf);
      u_host.wr(8'h0D, 8'h53);
      u_host.wr(8'h10, lf[7:0]);
      u_host.wr(8'h11, lf[15:8]);
      @(posedge clk);
      status_led_int <= lf[23:16];
      tick(3);
      note(4'h2, {24'h0, lf[7:0]});
      note(4'h3, {24'h0, lf[15:8]});
      u_host.strap(1'h1, 1'h0, 1'h0);
      tick(3);
      note(4'h2, {24'h0, lf[23:16]});
      note(4'h3, 32'h0);
      u_host.strap(1'h0, 1'h0, 1'h0);
      u_host.wr(8'h0D, 8'h50);
      tick(3);
      note(4'h2, {24'h0, lf[23:16]});
    end
    $display("led source test done");
    for (int i = 0; i < 8; i++) begin
      u_host.wr(8'h0F, ~(8'h01 << i) & (i == 5 ? 8'hBF : 8'hFF));
      src(i, 1'h1);
      tick(3);
      note(4'h1, 32'h0);
      u_host.wr(8'h0F, 8'hFF);
      tick(3);
      note(4'h1, 32'h1);
      note(4'h7, i < 5 ? 32'h40 >> i : i > 5 ? 32'(i - 5) : 32'h0);
      note(4'h8, i == 0 ? 32'h3 : (i == 5 ? 32'h0 : 32'h1));
      src(i, 1'h0);
    end
    u_host.strap(1'h1, 1'h0, 1'h0);
    u_host.wr(8'h0F, 8'h00);
    @(posedge clk);
    raw[1] <= 8'hFF;
    raw[4] <= 8'hFF;
    sc <= 3'h6;
    tick(3);
    note(4'h1, 32'h1);
    note(4'h8, 32'h5);
    src(0, 1'h1);
    tick(3);
    note(4'h1, 32'h0);
    @(posedge clk);
    raw <= '{default: 8'h00};
    sc <= 3'h0;
    u_host.strap(1'h0, 1'h0, 1'h0);
    tick(2100 * MS);
    $display("mask test done");
    src(1, 1'h1);
    tick(4);
    note(4'h3, 32'h1);
    src(1, 1'h0);
    for (int k = 0; k < 5; k++) begin
      u_host.strap(k == 4, 1'h0, 1'h0);
      u_host.wr(8'h0D, k == 4 ? 8'h54 : 8'h50 | 8'(k << 2));
      src(0, 1'h1);
      src(0, 1'h0);
      tick(k == 0 ? 6 : (k == 4 ? 2 : k) * 1000 * MS - 4);
      if (k > 0) note(4'h3, 32'h1);
      tick(12);
      note(4'h3, 32'h0);
    end
    $display("stretch test done");
    end_sim();
  end
endmodule // octal_switch_config_fault_mask_tb

// ===== dv/oscfm_core_props.sv
`timescale 1ns/10ps
module oscfm_core_props #(
  parameter int unsigned CH = 8,
  parameter int unsigned MS_CYCLES = 25000
) (
  input wire logic clk, // clock
  input wire logic rstn, // reset
  input wire logic daisy_strap, // strap
  input wire logic addr0_wdog_strap, // strap
  input wire logic addr1_sync_wdog_strap, // strap
  input wire logic [CH-1:0] overload_raw, // source
  input wire logic [CH-1:0] overcurrent_raw, // source
  input wire logic [CH-1:0] status_led_int, // pattern
  input wire logic [CH-1:0] status_led, // leds
  input wire logic fault_n, // pin
  input wire logic [CH-1:0] overload_flag, // flag
  input wire logic [CH-1:0] overcurrent_flag, // flag
  input wire logic [CH-1:0] openwire_off_flag, // flag
  input wire logic [CH-1:0] openwire_on_flag, // flag
  input wire logic [CH-1:0] supply_short_flag, // flag
  input wire logic spi_wdog_en, // enable
  input wire logic sync_wdog_enable, // enable
  input wire logic [31:0] wdog_spi_cycles, // timeout
  input wire logic restart_level_sel // level
);
  logic [1:0] alive;
  // two edges out of reset before outputs follow inputs
  always_ff @(posedge clk) begin
    alive <= rstn ? {alive[0], 1'h1} : 2'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_daisy;
    alive[1] && daisy_strap && $past(daisy_strap);
  endsequence
  sequence s_normal;
    alive[1] && !daisy_strap && !$past(daisy_strap);
  endsequence
  AST_DAISY_STATUS: assert property (s_daisy |-> status_led == $past(status_led_int))
    else $error("status leds not internal in daisy mode");
  AST_DAISY_RESTART: assert property (s_daisy |-> restart_level_sel)
    else $error("restart level not forced in daisy mode");
  AST_DAISY_WD_EN: assert property (s_daisy |-> spi_wdog_en == $past(addr0_wdog_strap)
    && sync_wdog_enable == $past(addr1_sync_wdog_strap)) else $error("watchdog enables not from straps");
  AST_DAISY_WD_TIME: assert property (s_daisy |-> wdog_spi_cycles == 32'(1200 * MS_CYCLES))
    else $error("daisy watchdog timeout wrong");
  AST_DAISY_NO_DET: assert property (s_daisy |-> (supply_short_flag | openwire_on_flag
    | openwire_off_flag | overcurrent_flag) == '0) else $error("detection active in daisy mode");
  AST_DAISY_FAULT: assert property (s_daisy ##0 $past(overload_raw) == '0 |-> fault_n)
    else $error("fault pin active without overload in daisy mode");
  AST_OVERLOAD_FLAG: assert property (alive[1] |-> overload_flag == $past(overload_raw))
    else $error("overload flag does not follow source");
  AST_OVERCUR_FLAG: assert property (s_normal |-> overcurrent_flag == $past(overcurrent_raw))
    else $error("current limit flag does not follow source");
endmodule // oscfm_core_props
bind oscfm_core oscfm_core_props #(.CH(CH), .MS_CYCLES(MS_CYCLES)) u_props (.clk, .rstn, .daisy_strap,
  .addr0_wdog_strap, .addr1_sync_wdog_strap, .overload_raw, .overcurrent_raw, .status_led_int, .status_led,
  .fault_n, .overload_flag, .overcurrent_flag, .openwire_off_flag, .openwire_on_flag, .supply_short_flag,
  .spi_wdog_en, .sync_wdog_enable, .wdog_spi_cycles, .restart_level_sel);

// ===== dv/oscfm_host.sv
`timescale 1ns/10ps
module oscfm_host (
  input wire logic clk, // clock
  output logic wr_en = 1'h0, // write strobe
  output logic [7:0] addr = 8'h00, // address
  output logic [7:0] wr_data = 8'h00, // data
  output logic daisy_strap = 1'h0, // strap
  output logic addr0_wdog_strap = 1'h0, // strap
  output logic addr1_sync_wdog_strap = 1'h0 // strap
);
  // released data shows the inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'h1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'h0;
    wr_data <= ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    repeat (2) @(posedge clk);
  endtask
  task automatic strap(input logic d, input logic a0, input logic a1);
    @(posedge clk);
    daisy_strap <= d;
    addr0_wdog_strap <= a0;
    addr1_sync_wdog_strap <= a1;
  endtask
endmodule // oscfm_host

// ===== logic/oscfm_core.sv
// Operation
// - stretch field 00 off, 01 1s, 10 2s, 11 3s minimum fault LED on-time.
// - daisy strap high forces 2s minimum fault LED on-time.
// - status source bit 1 uses software LED register, 0 internal drive.
// - daisy strap high always drives status LEDs internally.
// - fault source bit 1 uses software register, 0 internal diagnostics.
// - daisy strap high: fault LEDs show only per-channel overload.
// - watchdog field: 00 serial off/sync 600ms, else 200ms, 600ms, 1.2s.
// - daisy: both watchdogs 1.2s, each enabled by its address strap.
// - open-wire-off current code selects 20, 100, 300, 600 microamps.
// - short-to-supply threshold code selects 9V, 10V, 12V, 14V.
// - restart bit 1 selects supply-good level, 0 lockout release level.
// - daisy strap high always uses supply-good restart level.
// - comm mask keeps watchdog timeouts off fault pin, still flagged.
// - daisy: watchdog events only in comm error bit and global flag, never fault pin.
// - supply mask keeps supply errors off fault pin, still flagged.
// - daisy: supply errors never reach fault pin; lockout sets serial bit and supply summary.
// - good mask removes not-good and warning from supply summary.
// - short, open-on, open-off masks keep faults off pin, still flagged.
// - daisy disables short, open-wire detection and over-current reporting.
// - over-current mask keeps events off pin, still flagged.
// - overload mask keeps overloads off pin, still flagged.
// - internal fault LED lit at least minimum time, off after fault clears.
`timescale 1ns/10ps
`include "oscfm_params.svh"
module oscfm_core #(
  parameter int unsigned CH = 8,
  parameter int unsigned MS_CYCLES = `OSCFM_MS_CYCLES
) (
  input wire logic clk, // clock
  input wire logic rstn, // sync reset, low
  input wire logic wr_en, // register write strobe
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wr_data, // write data
  output logic [7:0] rd_data, // read data
  input wire logic daisy_strap, // daisy-chain strap
  input wire logic addr0_wdog_strap, // serial watchdog enable in daisy
  input wire logic addr1_sync_wdog_strap, // sync watchdog enable in daisy
  input wire logic [CH-1:0] overload_raw, // per-channel overload
  input wire logic [CH-1:0] overcurrent_raw, // per-channel current limit
  input wire logic [CH-1:0] openwire_off_raw, // open-wire off detection
  input wire logic [CH-1:0] openwire_on_raw, // open-wire on detection
  input wire logic [CH-1:0] supply_short_raw, // short-to-supply detection
  input wire logic [CH-1:0] status_led_int, // internal status pattern
  input wire logic spi_wdog_timeout, // serial watchdog expired
  input wire logic sync_wdog_timeout, // sync watchdog expired
  input wire logic supply_lockout, // other supply errors level
  input wire logic supply_below_good, // supply below good level
  input wire logic supply_warning, // supply warning level
  output logic [CH-1:0] status_led, // status leds
  output logic [CH-1:0] error_led, // fault leds
  output logic fault_n, // shared fault pin, low active
  output logic [CH-1:0] overload_flag, // overload fault bits
  output logic [CH-1:0] overcurrent_flag, // current limit bits
  output logic [CH-1:0] openwire_off_flag, // open-wire off bits
  output logic [CH-1:0] openwire_on_flag, // open-wire on bits
  output logic [CH-1:0] supply_short_flag, // short-to-supply bits
  output logic comm_error_irq, // comm error bit
  output logic supply_error_irq, // supply error summary
  output logic serial_supply_error_bit, // daisy serial supply bit
  output logic serial_overload_flag, // overload flag in frame
  output logic global_irq_flag, // global flag in frame
  output logic spi_wdog_en, // serial watchdog enabled
  output logic sync_wdog_enable, // sync watchdog enabled
  output logic [31:0] wdog_spi_cycles, // serial timeout in cycles
  output logic [31:0] wdog_sync_cycles, // sync timeout in cycles
  output logic [1:0] openwire_current_sel, // pull-up current code
  output logic [1:0] supply_short_thresh_sel, // threshold code
  output logic restart_level_sel, // 1 supply-good, 0 lockout release
  input wire logic [CH-1:0] supply_short_det_en, // short detection enable
  input wire logic [CH-1:0] openwire_on_det_en, // open-on detection enable
  input wire logic [CH-1:0] openwire_off_det_en // open-off detection enable
);
  import oscfm_pkg::*;
  logic [7:0] cfg1, next_cfg1;
  logic [7:0] cfg2, next_cfg2;
  logic [7:0] mask, next_mask;
  logic [7:0] status_led_sw_reg, next_status_led_sw_reg;
  logic [7:0] error_led_sw_reg, next_error_led_sw_reg;
  logic [7:0] next_rd_data;
  always_comb begin
    next_cfg1 = cfg1;
    next_cfg2 = cfg2;
    next_mask = mask;
    next_status_led_sw_reg = status_led_sw_reg;
    next_error_led_sw_reg = error_led_sw_reg;
    if (wr_en) begin
      if (addr == `OSCFM_ADDR_CFG1) begin
        next_cfg1 = wr_data;
      end else if (addr == `OSCFM_ADDR_CFG2) begin
        next_cfg2 = wr_data;
      end else if (addr == `OSCFM_ADDR_MASK) begin
        next_mask = wr_data;
      end else if (addr == `OSCFM_ADDR_STATUS_LED) begin
        next_status_led_sw_reg = wr_data;
      end else if (addr == `OSCFM_ADDR_ERROR_LED) begin
        next_error_led_sw_reg = wr_data;
      end
    end
  end
  // mode decode
  oscfm_stretch_t stretch;
  oscfm_wdog_t wdog_sel;
  logic [31:0] stretch_cycles;
  always_comb begin
    stretch = oscfm_stretch_t'({cfg1[`OSCFM_B_STRETCH_HI], cfg1[`OSCFM_B_STRETCH_LO]});
    wdog_sel = oscfm_wdog_t'({cfg2[`OSCFM_B_WDOG_HI], cfg2[`OSCFM_B_WDOG_LO]});
    case (stretch)
      OSCFM_STRETCH_1S: stretch_cycles = 32'(`OSCFM_T_1S_MS * MS_CYCLES);
      OSCFM_STRETCH_2S: stretch_cycles = 32'(2 * `OSCFM_T_1S_MS * MS_CYCLES);
      OSCFM_STRETCH_3S: stretch_cycles = 32'(3 * `OSCFM_T_1S_MS * MS_CYCLES);
      default: stretch_cycles = 32'h0;
    endcase
    if (daisy_strap) begin
      stretch_cycles = 32'(2 * `OSCFM_T_1S_MS * MS_CYCLES);
    end
  end
  logic [31:0] next_spi_cycles, next_sync_cycles;
  logic next_spi_en, next_sync_en;
  always_comb begin
    next_spi_en = 1'b1;
    next_sync_en = cfg2[`OSCFM_B_SYNC_WDOG];
    case (wdog_sel)
      OSCFM_WD_200MS: next_spi_cycles = 32'(`OSCFM_T_200MS * MS_CYCLES);
      OSCFM_WD_600MS: next_spi_cycles = 32'(`OSCFM_T_600MS * MS_CYCLES);
      OSCFM_WD_1200MS: next_spi_cycles = 32'(`OSCFM_T_1200MS * MS_CYCLES);
      default: begin
        next_spi_cycles = 32'(`OSCFM_T_600MS * MS_CYCLES);
        next_spi_en = 1'b0;
      end
    endcase
    next_sync_cycles = next_spi_cycles;
    if (daisy_strap) begin
      next_spi_cycles = 32'(`OSCFM_T_1200MS * MS_CYCLES);
      next_sync_cycles = 32'(`OSCFM_T_1200MS * MS_CYCLES);
      next_spi_en = addr0_wdog_strap;
      next_sync_en = addr1_sync_wdog_strap;
    end
  end
  // diagnostics: daisy gates off detections and over-current, fault pin keeps only overload
  logic [CH-1:0] short_act, owon_act, owoff_act, ocur_act;
  logic comm_err, supply_sum, fault_any;
  always_comb begin
    short_act = daisy_strap ? '0 : (supply_short_raw & supply_short_det_en);
    owon_act = daisy_strap ? '0 : (openwire_on_raw & openwire_on_det_en);
    owoff_act = daisy_strap ? '0 : (openwire_off_raw & openwire_off_det_en);
    ocur_act = daisy_strap ? '0 : overcurrent_raw;
    comm_err = spi_wdog_timeout | sync_wdog_timeout;
    supply_sum = supply_lockout |
      (!mask[`OSCFM_B_M_GOOD] && !daisy_strap && (supply_below_good | supply_warning));
    fault_any = 1'b0;
    if (!daisy_strap) begin
      fault_any = (comm_err & !mask[`OSCFM_B_M_COMM]) |
        (supply_sum & !mask[`OSCFM_B_M_SUPPLY]) |
        ((|short_act) & !mask[`OSCFM_B_M_SHORT]) |
        ((|owon_act) & !mask[`OSCFM_B_M_OWON]) |
        ((|owoff_act) & !mask[`OSCFM_B_M_OWOFF]) |
        ((|ocur_act) & !mask[`OSCFM_B_M_OVERCUR]);
    end
    fault_any = fault_any | ((|overload_raw) & !mask[`OSCFM_B_M_OVERLOAD]);
  end
  // per-channel fault led
  logic [CH-1:0] led_src, led_str;
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_led
      assign led_src[g] = daisy_strap ? overload_raw[g] :
        (overload_raw[g] | ocur_act[g] | owoff_act[g] | owon_act[g] | short_act[g]);
      oscfm_led_stretch #(.CNT_W(32)) u_str (
        .clk(clk),
        .rstn(rstn),
        .fault(led_src[g]),
        .min_cycles(stretch_cycles),
        .led(led_str[g])
      );
    end
  endgenerate
  logic [CH-1:0] next_status_led, next_error_led;
  logic next_fault_n, next_comm, next_supply, next_serial_supply, next_glob;
  always_comb begin
    next_status_led = (cfg1[`OSCFM_B_STATUS_LED_SRC] && !daisy_strap) ?
      status_led_sw_reg[CH-1:0] : status_led_int;
    next_error_led = (cfg1[`OSCFM_B_ERR_LED_SRC] && !daisy_strap) ?
      error_led_sw_reg[CH-1:0] : led_str;
    next_fault_n = !fault_any;
    next_comm = comm_err;
    next_supply = supply_sum;
    next_serial_supply = daisy_strap & supply_lockout;
    next_glob = comm_err | supply_sum | (|overload_raw) | (|ocur_act) |
      (|owon_act) | (|owoff_act) | (|short_act);
    if (addr == `OSCFM_ADDR_CFG1) begin
      next_rd_data = cfg1;
    end else if (addr == `OSCFM_ADDR_CFG2) begin
      next_rd_data = cfg2;
    end else if (addr == `OSCFM_ADDR_MASK) begin
      next_rd_data = mask;
    end else if (addr == `OSCFM_ADDR_STATUS_LED) begin
      next_rd_data = status_led_sw_reg;
    end else if (addr == `OSCFM_ADDR_ERROR_LED) begin
      next_rd_data = error_led_sw_reg;
    end else if (addr == `OSCFM_ADDR_SUPPLY_SUMMARY) begin
      next_rd_data = {6'h00, comm_err, supply_sum};
    end else begin
      next_rd_data = 8'h00;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg1 <= `OSCFM_CFG1_RESET;
      cfg2 <= `OSCFM_CFG2_RESET;
      mask <= `OSCFM_MASK_RESET;
      status_led_sw_reg <= 8'h00;
      error_led_sw_reg <= 8'h00;
      rd_data <= 8'h00;
      status_led <= '0;
      error_led <= '0;
      fault_n <= 1'b1;
      overload_flag <= '0;
      overcurrent_flag <= '0;
      openwire_off_flag <= '0;
      openwire_on_flag <= '0;
      supply_short_flag <= '0;
      comm_error_irq <= 1'b0;
      supply_error_irq <= 1'b0;
      serial_supply_error_bit <= 1'b0;
      serial_overload_flag <= 1'b0;
      global_irq_flag <= 1'b0;
      spi_wdog_en <= 1'b0;
      sync_wdog_enable <= 1'b0;
      wdog_spi_cycles <= 32'h0;
      wdog_sync_cycles <= 32'h0;
      openwire_current_sel <= 2'h0;
      supply_short_thresh_sel <= 2'h0;
      restart_level_sel <= 1'b0;
    end else begin
      cfg1 <= next_cfg1;
      cfg2 <= next_cfg2;
      mask <= next_mask;
      status_led_sw_reg <= next_status_led_sw_reg;
      error_led_sw_reg <= next_error_led_sw_reg;
      rd_data <= next_rd_data;
      status_led <= next_status_led;
      error_led <= next_error_led;
      fault_n <= next_fault_n;
      overload_flag <= overload_raw;
      overcurrent_flag <= ocur_act;
      openwire_off_flag <= owoff_act;
      openwire_on_flag <= owon_act;
      supply_short_flag <= short_act;
      comm_error_irq <= next_comm;
      supply_error_irq <= next_supply;
      serial_supply_error_bit <= next_serial_supply;
      serial_overload_flag <= |overload_raw;
      global_irq_flag <= next_glob;
      spi_wdog_en <= next_spi_en;
      sync_wdog_enable <= next_sync_en;
      wdog_spi_cycles <= next_spi_cycles;
      wdog_sync_cycles <= next_sync_cycles;
      openwire_current_sel <= {cfg2[`OSCFM_B_OWCUR_HI], cfg2[`OSCFM_B_OWCUR_LO]};
      supply_short_thresh_sel <= {cfg2[`OSCFM_B_SHORT_HI], cfg2[`OSCFM_B_SHORT_LO]};
      restart_level_sel <= cfg2[`OSCFM_B_RESTART] | daisy_strap;
    end
  end
endmodule // oscfm_core

// ===== logic/oscfm_led_stretch.sv
`timescale 1ns/10ps
`include "oscfm_params.svh"
module oscfm_led_stretch #(
  parameter int unsigned CNT_W = 32
) (
  input wire logic clk, // clock
  input wire logic rstn, // sync reset, low
  input wire logic fault, // internal fault level
  input wire logic [CNT_W-1:0] min_cycles, // minimum on-time, 0 = off
  output logic led // stretched led
);
  import oscfm_pkg::*;
  oscfm_led_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic next_led;
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_led = fault;
    case (state)
      OSCFM_LED_IDLE: begin
        if (fault && min_cycles != '0) begin
          next_state = OSCFM_LED_HOLD;
          next_cnt = min_cycles - CNT_W'(1);
        end
      end
      OSCFM_LED_HOLD: begin
        next_led = 1'b1;
        if (cnt != '0) begin
          next_cnt = cnt - CNT_W'(1);
        end else if (!fault) begin
          next_state = OSCFM_LED_IDLE;
          next_led = 1'b0;
        end
      end
      default: next_state = OSCFM_LED_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= OSCFM_LED_IDLE;
      cnt <= '0;
      led <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      led <= next_led;
    end
  end
endmodule // oscfm_led_stretch

// ===== logic/oscfm_params.svh
`ifndef OSCFM_PARAMS_SVH
`define OSCFM_PARAMS_SVH
// register offsets (documented port: address from serial decoder)
`define OSCFM_ADDR_CFG1 8'h0D
`define OSCFM_ADDR_CFG2 8'h0E
`define OSCFM_ADDR_MASK 8'h0F
`define OSCFM_ADDR_STATUS_LED 8'h10
`define OSCFM_ADDR_ERROR_LED 8'h11
`define OSCFM_ADDR_SUPPLY_SUMMARY 8'h12
// reset values
`define OSCFM_CFG1_RESET 8'h53
`define OSCFM_CFG2_RESET 8'h00
`define OSCFM_MASK_RESET 8'hBE
// config1 fields
`define OSCFM_B_ERR_LED_SRC 0
`define OSCFM_B_STATUS_LED_SRC 1
`define OSCFM_B_STRETCH_LO 2
`define OSCFM_B_STRETCH_HI 3
// watchdog_and_threshold_config fields
`define OSCFM_B_RESTART 0
`define OSCFM_B_SYNC_WDOG 1
`define OSCFM_B_SHORT_LO 2
`define OSCFM_B_SHORT_HI 3
`define OSCFM_B_OWCUR_LO 4
`define OSCFM_B_OWCUR_HI 5
`define OSCFM_B_WDOG_LO 6
`define OSCFM_B_WDOG_HI 7
// mask fields
`define OSCFM_B_M_OVERLOAD 0
`define OSCFM_B_M_OVERCUR 1
`define OSCFM_B_M_OWOFF 2
`define OSCFM_B_M_OWON 3
`define OSCFM_B_M_SHORT 4
`define OSCFM_B_M_GOOD 5
`define OSCFM_B_M_SUPPLY 6
`define OSCFM_B_M_COMM 7
// timing, milliseconds, at 25 MHz
`define OSCFM_CLK_HZ 25000000
`define OSCFM_T_1S_MS 1000
`define OSCFM_T_200MS 200
`define OSCFM_T_600MS 600
`define OSCFM_T_1200MS 1200
`define OSCFM_MS_CYCLES (`OSCFM_CLK_HZ / 1000)
`endif

// ===== logic/oscfm_pkg.sv
package oscfm_pkg;
  typedef enum logic [1:0] {
    OSCFM_STRETCH_OFF,
    OSCFM_STRETCH_1S,
    OSCFM_STRETCH_2S,
    OSCFM_STRETCH_3S
  } oscfm_stretch_t;
  typedef enum logic [1:0] {
    OSCFM_WD_SPI_OFF,
    OSCFM_WD_200MS,
    OSCFM_WD_600MS,
    OSCFM_WD_1200MS
  } oscfm_wdog_t;
  typedef enum logic {
    OSCFM_LED_IDLE,
    OSCFM_LED_HOLD
  } oscfm_led_state_t;
endpackage
